// File: inc/panel_map.svh
// register offsets, field positions, reset values and timing for the panel block
`ifndef PANEL_MAP_SVH
`define PANEL_MAP_SVH
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_IRQ_STAT 12'h008
`define OFS_IRQ_MASK 12'h00C
`define OFS_ALARM_TEXT 12'h010
`define OFS_LED 12'h014
`define OFS_DISPLAY 12'h018
`define CTRL_ACT_POS 0
`define CTRL_IDLE_POS 2
`define CTRL_LOCAL_POS 4
`define CTRL_REMOTE_POS 5
`define CTRL_EBNO_THR_POS 8
`define CTRL_RESTORE_POS 31
`define ACT_LEVEL_RST 2'h3
`define IDLE_LEVEL_RST 2'h1
`define EBNO_THR_RST 8'h28
`define IRQ_KEY_BIT 0
`define IRQ_IDLE_BIT 1
`define IRQ_ALARM_BIT 2
`define CLK_HZ 20000000
`define IDLE_TIME_S 60
`define BLINK_HALF_MS 500
`define PWM_STEPS 3
`endif

// File: inc/panel_pkg.sv
// types shared by the panel block
`default_nettype none
package panel_pkg;
	typedef enum logic [1:0] {
		level_off,
		level_third,
		level_two_thirds,
		level_full
	} level_e;
	typedef enum logic {
		bl_idle,
		bl_active
	} bl_state_e;
	typedef enum logic [3:0] {
		alm_none,
		alm_mod_fault,
		alm_demod_fault,
		alm_mod_warn,
		alm_low_level,
		alm_low_ebno,
		alm_backward,
		alm_test
	} alarm_text_e;
endpackage : panel_pkg
`default_nettype wire

// File: logic/front_panel_indicator_control.sv
// front panel leds, lcd backlight and alarm text selection with axi4-lite regs
// Functional notes
// RULE1: key press forces backlight active at once
// RULE2: sixty idle seconds drop backlight to idle
// RULE3: each state has off/third/two-thirds/full level
// RULE4: restored defaults: active full, idle one-third
// RULE5: green normal, yellow improper, red traffic loss
// RULE6: lit alarm shows highest-priority alarm text
// RULE7: unit alarm red is alarm one OR two
// RULE8: local and remote green follow control setting
// RULE9: tx on steady, flashes in loopback carrier-off
// RULE10: mod major red on transmit failure
// RULE11: mod minor yellow on transmit warning
// RULE12: mod test yellow flashes during mod test
// RULE13: rx lock green needs carrier, data, fec
// RULE14: demod major red on receive failure
// RULE15: demod minor: low level, low ebno, backward
// RULE16: demod test yellow flashes during rx test
// RULE17: display fields: column, parameter, value line (only column and parameter are passed to the lcd)
// RULE18: one shared one hertz equal-phase blink
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "panel_map.svh"
`default_nettype none
module front_panel_indicator_control #(
	parameter int unsigned IDLE_CYCLES = `IDLE_TIME_S * `CLK_HZ,
	parameter int unsigned BLINK_HALF_CYCLES =
		`BLINK_HALF_MS * (`CLK_HZ / 1000)
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// keypad, any key, from a pin
	input wire logic key_pressed,
	// modem status from modem logic
	input wire logic tx_output_active,
	input wire logic if_loopback,
	input wire logic carrier_disabled,
	input wire logic tx_failed,
	input wire logic tx_warning,
	input wire logic mod_test,
	input wire logic rx_carrier_lock,
	input wire logic rx_data_lock,
	input wire logic rx_fec_sync,
	input wire logic rx_failed,
	input wire logic rx_low_level,
	input wire logic [7:0] rx_ebno,
	input wire logic rx_backward_alarm,
	input wire logic demod_test,
	input wire logic alarm_out_one,
	input wire logic alarm_out_two,
	input wire logic power_good,
	// display content from the menu processor
	input wire logic [1:0] disp_column,
	input wire logic [5:0] disp_param,
	// display content to the lcd
	output logic [1:0] lcd_column,
	output logic [5:0] lcd_param,
	output logic lcd_show_alarm,
	output logic [3:0] lcd_alarm_text,
	// backlight
	output logic backlight_on,
	output logic backlight_active,
	// leds: power, alarm, local, remote
	output logic led_power_green,
	output logic led_unit_alarm_red,
	output logic led_local_green,
	output logic led_remote_green,
	// leds: modulator column
	output logic led_tx_on_green,
	output logic led_mod_major_red,
	output logic led_mod_minor_yellow,
	output logic led_mod_test_yellow,
	// leds: demodulator column
	output logic led_rx_lock_green,
	output logic led_demod_major_red,
	output logic led_demod_minor_yellow,
	output logic led_demod_test_yellow,
	// interrupt
	output logic irq
);
	// key pin synchroniser, second stage only is used
	logic key_s1_q, key_s2_q, key_prev_q, key_edge;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			key_s1_q <= 1'b0;
			key_s2_q <= 1'b0;
			key_prev_q <= 1'b0;
		end else begin
			key_s1_q <= key_pressed;
			key_s2_q <= key_s1_q;
			key_prev_q <= key_s2_q;
		end
	end
	assign key_edge = key_s2_q & ~key_prev_q;

	// control register fields
	logic [1:0] act_level_q, idle_level_q;
	logic local_q, remote_q;
	logic [7:0] ebno_thr_q;
	logic [2:0] irq_stat_q, irq_mask_q;
	// axi write channel: address and data taken in either order
	logic aw_held_q, w_held_q, wr_fire;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready = !w_held_q && !s_axi_bvalid;
	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awaddr_q)
				`OFS_CTRL, `OFS_IRQ_STAT, `OFS_IRQ_MASK: s_axi_bresp <= 2'h0;
				default: s_axi_bresp <= 2'h2;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register writes; restore bit reloads the active and idle level defaults
	logic wr_ctrl, wr_stat;
	assign wr_ctrl = wr_fire && awaddr_q == `OFS_CTRL;
	assign wr_stat = wr_fire && awaddr_q == `OFS_IRQ_STAT && wstrb_q[0];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			act_level_q <= `ACT_LEVEL_RST; // RULE4
			idle_level_q <= `IDLE_LEVEL_RST; // RULE4
			local_q <= 1'b1;
			remote_q <= 1'b1;
			ebno_thr_q <= `EBNO_THR_RST;
			irq_mask_q <= 3'h0;
		end else if (wr_ctrl && wstrb_q[3] && wdata_q[`CTRL_RESTORE_POS]) begin
			act_level_q <= `ACT_LEVEL_RST; // RULE4
			idle_level_q <= `IDLE_LEVEL_RST; // RULE4
		end else begin
			if (wr_ctrl && wstrb_q[0]) begin
				act_level_q <= wdata_q[`CTRL_ACT_POS +: 2]; // RULE3
				idle_level_q <= wdata_q[`CTRL_IDLE_POS +: 2]; // RULE3
				local_q <= wdata_q[`CTRL_LOCAL_POS];
				remote_q <= wdata_q[`CTRL_REMOTE_POS];
			end
			if (wr_ctrl && wstrb_q[1])
				ebno_thr_q <= wdata_q[`CTRL_EBNO_THR_POS +: 8];
			if (wr_fire && awaddr_q == `OFS_IRQ_MASK && wstrb_q[0])
				irq_mask_q <= wdata_q[2:0];
		end
	end

	// backlight timer, restarted on every key press
	logic [31:0] idle_cnt_q;
	logic bl_active_q, idle_event;
	assign idle_event = bl_active_q && !key_edge && idle_cnt_q == 32'h1;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idle_cnt_q <= IDLE_CYCLES;
			bl_active_q <= 1'b1;
		end else if (key_edge) begin
			idle_cnt_q <= IDLE_CYCLES; // RULE2
			bl_active_q <= 1'b1; // RULE1
		end else if (idle_cnt_q != 32'h0) begin
			idle_cnt_q <= idle_cnt_q - 32'h1;
			if (idle_cnt_q == 32'h1)
				bl_active_q <= 1'b0; // RULE2
		end
	end
	// brightness pwm in thirds; off never lights, full always
	logic [1:0] pwm_q, level_now;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pwm_q <= 2'h0;
		else
			pwm_q <= (pwm_q == 2'(`PWM_STEPS - 1)) ? 2'h0 : pwm_q + 2'h1;
	end
	assign level_now = bl_active_q ? act_level_q : idle_level_q; // RULE3
	always_ff @(posedge aclk) begin
		if (!aresetn)
			backlight_on <= 1'b0;
		else
			backlight_on <= pwm_q < level_now; // RULE3
	end
	assign backlight_active = bl_active_q;
	// shared blink enable, equal on and off halves
	logic [31:0] blink_cnt_q;
	logic blink_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			blink_cnt_q <= 32'h0;
			blink_q <= 1'b0;
		end else if (blink_cnt_q == BLINK_HALF_CYCLES - 1) begin
			blink_cnt_q <= 32'h0;
			blink_q <= ~blink_q; // RULE18
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h1;
		end
	end
	// status inputs are same-clock logic and need no synchroniser
	logic low_ebno, tx_flash, demod_minor;
	assign low_ebno = rx_ebno < ebno_thr_q;
	assign tx_flash = if_loopback && carrier_disabled;
	assign demod_minor = rx_low_level | low_ebno | rx_backward_alarm;

	// led drive, each lamp wired to one colour only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			led_power_green <= 1'b0;
			led_unit_alarm_red <= 1'b0;
			led_local_green <= 1'b0;
			led_remote_green <= 1'b0;
			led_tx_on_green <= 1'b0;
			led_mod_major_red <= 1'b0;
			led_mod_minor_yellow <= 1'b0;
			led_mod_test_yellow <= 1'b0;
			led_rx_lock_green <= 1'b0;
			led_demod_major_red <= 1'b0;
			led_demod_minor_yellow <= 1'b0;
			led_demod_test_yellow <= 1'b0;
		end else begin
			led_power_green <= power_good; // RULE5
			led_unit_alarm_red <= alarm_out_one | alarm_out_two; // RULE7
			led_local_green <= local_q; // RULE8
			led_remote_green <= remote_q; // RULE8
			// flash wins, a looped-back carrier is not really sending
			led_tx_on_green <= tx_flash ? blink_q : tx_output_active; // RULE9
			led_mod_major_red <= tx_failed; // RULE10
			led_mod_minor_yellow <= tx_warning; // RULE11
			led_mod_test_yellow <= mod_test & blink_q; // RULE12
			led_rx_lock_green <= rx_carrier_lock & rx_data_lock
				& rx_fec_sync; // RULE13
			led_demod_major_red <= rx_failed; // RULE14
			led_demod_minor_yellow <= demod_minor; // RULE15
			led_demod_test_yellow <= demod_test & blink_q; // RULE16
		end
	end

	// highest-priority alarm text, faults before warnings
	logic any_alarm;
	logic [3:0] alarm_sel;
	assign any_alarm = alarm_out_one | alarm_out_two | tx_failed | rx_failed
		| tx_warning | demod_minor;
	always_comb begin
		if (tx_failed)
			alarm_sel = panel_pkg::alm_mod_fault;
		else if (rx_failed)
			alarm_sel = panel_pkg::alm_demod_fault;
		else if (tx_warning)
			alarm_sel = panel_pkg::alm_mod_warn;
		else if (rx_low_level)
			alarm_sel = panel_pkg::alm_low_level;
		else if (low_ebno)
			alarm_sel = panel_pkg::alm_low_ebno;
		else if (rx_backward_alarm)
			alarm_sel = panel_pkg::alm_backward;
		else if (mod_test | demod_test)
			alarm_sel = panel_pkg::alm_test;
		else
			alarm_sel = panel_pkg::alm_none;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lcd_show_alarm <= 1'b0;
			lcd_alarm_text <= 4'h0;
			lcd_column <= 2'h0;
			lcd_param <= 6'h00;
		end else begin
			lcd_show_alarm <= any_alarm; // RULE6
			lcd_alarm_text <= alarm_sel; // RULE6
			lcd_column <= disp_column; // RULE17
			lcd_param <= disp_param; // RULE17
		end
	end

	// sticky events; a set in the clearing cycle survives
	logic [2:0] ev;
	logic alarm_prev_q;
	assign ev = {any_alarm & ~alarm_prev_q, idle_event, key_edge};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= 3'h0;
			alarm_prev_q <= 1'b0;
		end else begin
			alarm_prev_q <= any_alarm;
			irq_stat_q <= (irq_stat_q & ~(wr_stat ? wdata_q[2:0] : 3'h0)) | ev;
		end
	end
	assign irq = |(irq_stat_q & irq_mask_q);

	// axi read channel, one cycle after address
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case (s_axi_araddr)
			`OFS_CTRL: s_axi_rdata <= {16'h0000, ebno_thr_q, 2'h0,
				remote_q, local_q, idle_level_q, act_level_q};
			`OFS_STATUS: s_axi_rdata <= {29'h0, any_alarm, bl_active_q,
				backlight_on};
			`OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_q};
			`OFS_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_q};
			`OFS_ALARM_TEXT: s_axi_rdata <= {27'h0, lcd_show_alarm,
				lcd_alarm_text};
			`OFS_LED: s_axi_rdata <= {20'h0, led_demod_test_yellow,
				led_demod_minor_yellow, led_demod_major_red,
				led_rx_lock_green, led_mod_test_yellow,
				led_mod_minor_yellow, led_mod_major_red, led_tx_on_green,
				led_remote_green, led_local_green, led_unit_alarm_red,
				led_power_green};
			`OFS_DISPLAY: s_axi_rdata <= {24'h0, lcd_param, lcd_column};
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= 2'h2;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : front_panel_indicator_control
`default_nettype wire

// File: testbench/panel_checker.sv
// checker of led, backlight and alarm text timing for the panel block
`timescale 1ns/1ns
`default_nettype none
module panel_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// causes
	input wire logic key_pressed,
	input wire logic tx_failed,
	input wire logic tx_warning,
	input wire logic alarm_out_one,
	input wire logic alarm_out_two,
	input wire logic rx_failed,
	input wire logic rx_carrier_lock,
	input wire logic rx_data_lock,
	input wire logic rx_fec_sync,
	input wire logic mod_test,
	// effects
	input wire logic backlight_active,
	input wire logic led_mod_major_red,
	input wire logic led_mod_minor_yellow,
	input wire logic led_unit_alarm_red,
	input wire logic led_demod_major_red,
	input wire logic led_rx_lock_green,
	input wire logic led_mod_test_yellow,
	input wire logic lcd_show_alarm
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// leds follow their inputs one cycle later, mod test led only lit after mod_test, guarded after reset
	property p_unit;
		$past(aresetn) |->
			led_unit_alarm_red == $past(alarm_out_one | alarm_out_two);
	endproperty
	a_unit: assert property (p_unit) else $error("unit alarm led wrong");
	property p_mod_major;
		$past(aresetn) |-> led_mod_major_red == $past(tx_failed);
	endproperty
	a_mod_major: assert property (p_mod_major) else $error("mod major wrong");
	property p_mod_minor;
		$past(aresetn) |-> led_mod_minor_yellow == $past(tx_warning);
	endproperty
	a_mod_minor: assert property (p_mod_minor) else $error("mod minor wrong");
	property p_demod_major;
		$past(aresetn) |-> led_demod_major_red == $past(rx_failed);
	endproperty
	a_demod_major: assert property (p_demod_major) else $error("dmaj wrong");
	property p_lock;
		$past(aresetn) |-> led_rx_lock_green ==
			$past(rx_carrier_lock & rx_data_lock & rx_fec_sync);
	endproperty
	a_lock: assert property (p_lock) else $error("rx lock led wrong");
	property p_test;
		$past(aresetn) && led_mod_test_yellow |-> $past(mod_test);
	endproperty
	a_test: assert property (p_test) else $error("mod test led unasked");
	// key path: two sync flops and an edge detect
	property p_key;
		$rose(key_pressed) |-> ##[1:5] backlight_active;
	endproperty
	a_key: assert property (p_key) else $error("backlight not active");
	property p_show;
		led_mod_major_red || led_demod_major_red |-> ##[0:1] lcd_show_alarm;
	endproperty
	a_show: assert property (p_show) else $error("alarm text not shown");
	c_unit: cover property (led_unit_alarm_red && lcd_show_alarm);
	c_idle: cover property ($fell(backlight_active));
	c_blink: cover property (led_mod_test_yellow ##1 !led_mod_test_yellow);
endmodule : panel_checker
`default_nettype wire

// File: testbench/panel_keypad_model.sv
// keypad model: holds the any-key line for a chosen number of cycles
`timescale 1ns/1ns
`default_nettype none
module panel_keypad_model (
	// clock
	input wire logic aclk,
	// press request and hold length
	input wire logic go,
	input wire logic [3:0] hold,
	// key line toward the panel
	output logic key_pressed
);
	logic [3:0] left_q = 4'h0;
	// a released key reads low, so the line idles unpressed
	always_ff @(posedge aclk) begin
		if (go)
			left_q <= hold;
		else if (left_q != 4'h0)
			left_q <= left_q - 4'h1;
	end
	assign key_pressed = left_q != 4'h0;
endmodule : panel_keypad_model
`default_nettype wire

// File: testbench/front_panel_indicator_control_test.sv
// self-checking bench of the panel block
`timescale 1ns/1ns
`include "panel_map.svh"
`default_nettype none
module front_panel_indicator_control_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, r;
	logic [3:0] s_axi_wstrb, hold, txt;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	logic tx_output_active, if_loopback, carrier_disabled;
	logic tx_failed, tx_warning;
	logic mod_test, rx_carrier_lock, rx_data_lock, rx_fec_sync, rx_failed;
	logic rx_low_level, rx_backward_alarm, demod_test, alarm_out_one;
	logic alarm_out_two, power_good, go, probe, low_eb, show;
	logic [7:0] rx_ebno;
	logic [1:0] disp_column;
	logic [5:0] disp_param;
	wire logic key_pressed, s_axi_awready, s_axi_wready, s_axi_bvalid;
	wire logic s_axi_arready, s_axi_rvalid, lcd_show_alarm, backlight_on;
	wire logic backlight_active, irq, led_power_green, led_unit_alarm_red;
	wire logic led_local_green, led_remote_green, led_tx_on_green;
	wire logic led_mod_major_red, led_mod_minor_yellow, led_mod_test_yellow;
	wire logic led_rx_lock_green, led_demod_major_red, led_demod_minor_yellow;
	wire logic led_demod_test_yellow;
	wire logic [1:0] s_axi_bresp, s_axi_rresp, lcd_column;
	wire logic [31:0] s_axi_rdata;
	wire logic [5:0] lcd_param;
	wire logic [3:0] lcd_alarm_text;
	logic [33:0] exp_q[$];
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	int n0, n1, n2, n3;
	// text is hidden while no alarm is shown
	wire logic [16:0] obs = {lcd_show_alarm ? lcd_alarm_text : 4'h0,
		lcd_show_alarm, led_power_green, led_unit_alarm_red, led_local_green,
		led_remote_green, led_tx_on_green, led_mod_major_red,
		led_mod_minor_yellow, led_mod_test_yellow, led_rx_lock_green,
		led_demod_major_red, led_demod_minor_yellow, led_demod_test_yellow};
	// short idle and blink counts keep the run brief
	front_panel_indicator_control #(.IDLE_CYCLES(200), .BLINK_HALF_CYCLES(4))
		i_dut (.*);
	panel_keypad_model i_keys (.aclk(aclk), .go(go), .hold(hold),
		.key_pressed(key_pressed));
	// 20 MHz clock
	always #25 aclk = ~aclk;
	task chk(input logic [33:0] seen, input logic [33:0] want);
		comparisons++;
		if (seen !== want) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	task tally_and_finish;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	// results are matched against the oldest note as they appear
	always @(posedge aclk) begin
		if (aresetn && s_axi_bvalid && s_axi_bready)
			chk(34'(s_axi_bresp), exp_q.pop_front());
		if (aresetn && s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		if (probe)
			chk(34'(obs), exp_q.pop_front());
	end
	// hang guard
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 6000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rsp);
		exp_q.push_back(34'(rsp));
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// each channel is let go only at the edge that takes it
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
		// one edge between calls, so no signal is set twice in a step
		@(posedge aclk);
	endtask : wr
	task rd(input logic [11:0] a, input logic [33:0] want);
		exp_q.push_back(want);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	task press;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
	endtask : press
	task count(input int n);
		{n0, n1, n2, n3} = '0;
		repeat (n) begin
			@(posedge aclk);
			n0 += backlight_on;
			n1 += led_tx_on_green;
			n2 += led_mod_test_yellow;
			n3 += led_demod_test_yellow;
		end
	endtask : count
	task probe_leds(input logic [16:0] e);
		exp_q.push_back(34'(e));
		probe <= 1'b1;
		@(posedge aclk);
		probe <= 1'b0;
	endtask : probe_leds
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid,
			s_axi_bready, s_axi_arvalid, s_axi_rready, tx_output_active,
			if_loopback, carrier_disabled, tx_failed, tx_warning, mod_test,
			rx_carrier_lock, rx_data_lock, rx_fec_sync, rx_failed, rx_low_level,
			rx_backward_alarm, demod_test, alarm_out_one, alarm_out_two,
			power_good, go, probe, rx_ebno, disp_column, disp_param} = '0;
		s_axi_wstrb = 4'hF;
		hold = 4'h4;
		r = $urandom(32'hA58904A1);
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`OFS_CTRL, 34'h2837);
		rd(12'h100, {2'h2, 32'h0});
		wr(`OFS_LED, 32'h0, 2'h2);
		$display("reset test done");
		for (int lv = 0; lv < 4; lv++) begin
			wr(`OFS_CTRL, 32'h2834 | 32'(lv), 2'h0);
			press;
			repeat (8) @(posedge aclk);
			count(30);
			chk(34'(n0), 34'(10 * lv));
		end
		$display("level test done");
		press;
		repeat (150) @(posedge aclk);
		chk(34'(backlight_active), 34'h1);
		press;
		repeat (150) @(posedge aclk);
		chk(34'(backlight_active), 34'h1);
		repeat (100) @(posedge aclk);
		chk(34'(backlight_active), 34'h0);
		count(30);
		chk(34'(n0), 34'd10);
		press;
		repeat (5) @(posedge aclk);
		chk(34'(backlight_active), 34'h1);
		wr(`OFS_CTRL, 32'h2830, 2'h0);
		wr(`OFS_CTRL, 32'h80002830, 2'h0);
		rd(`OFS_CTRL, 34'h2837);
		$display("backlight test done");
		for (int i = 0; i < 24; i++) begin
			r = $urandom;
			wr(`OFS_CTRL, {16'h0, 8'h28, 2'b00, r[13:12], 4'h7}, 2'h0);
			{tx_output_active, tx_failed, tx_warning, rx_carrier_lock,
				rx_data_lock, rx_fec_sync, rx_failed, rx_low_level,
				rx_backward_alarm, alarm_out_one, alarm_out_two,
				power_good} <= r[11:0];
			rx_ebno <= 8'h26 + 8'(r[15:14]);
			repeat (3) @(posedge aclk);
			low_eb = rx_ebno < 8'h28;
			show = alarm_out_one | alarm_out_two | tx_failed | rx_failed
				| tx_warning | rx_low_level | low_eb | rx_backward_alarm;
			txt = tx_failed ? panel_pkg::alm_mod_fault
				: rx_failed ? panel_pkg::alm_demod_fault
				: tx_warning ? panel_pkg::alm_mod_warn
				: rx_low_level ? panel_pkg::alm_low_level
				: low_eb ? panel_pkg::alm_low_ebno
				: rx_backward_alarm ? panel_pkg::alm_backward
				: panel_pkg::alm_none;
			probe_leds({show ? txt : 4'h0, show, power_good,
				alarm_out_one | alarm_out_two, r[12], r[13], tx_output_active,
				tx_failed, tx_warning, 1'b0,
				rx_carrier_lock & rx_data_lock & rx_fec_sync, rx_failed,
				rx_low_level | low_eb | rx_backward_alarm, 1'b0});
		end
		$display("led test done");
		{tx_output_active, if_loopback, carrier_disabled, mod_test,
			demod_test} <= 5'h1F;
		repeat (3) @(posedge aclk);
		count(16);
		chk(34'(n1), 34'd8);
		chk(34'(n2), 34'd8);
		chk(34'(n3), 34'd8);
		if_loopback <= 1'b0;
		repeat (3) @(posedge aclk);
		count(16);
		chk(34'(n1), 34'd16);
		$display("blink test done");
		wr(`OFS_IRQ_MASK, 32'h1, 2'h0);
		wr(`OFS_IRQ_STAT, 32'h7, 2'h0);
		chk(34'(irq), 34'h0);
		press;
		repeat (6) @(posedge aclk);
		chk(34'(irq), 34'h1);
		wr(`OFS_IRQ_MASK, 32'h0, 2'h0);
		chk(34'(irq), 34'h0);
		wr(`OFS_IRQ_STAT, 32'h1, 2'h0);
		wr(`OFS_IRQ_MASK, 32'h1, 2'h0);
		chk(34'(irq), 34'h0);
		$display("interrupt test done");
		disp_column <= 2'h2;
		disp_param <= 6'h2A;
		repeat (3) @(posedge aclk);
		chk(34'({lcd_column, lcd_param}), 34'hAA);
		rd(`OFS_DISPLAY, 34'hAA);
		$display("display test done");
		tally_and_finish;
	end
endmodule : front_panel_indicator_control_test
bind front_panel_indicator_control panel_checker i_chk (.*);
`default_nettype wire
